// File: shared/acsf_consts.vh
// Behaviour
// - Start assertion delays only the first conversion by the programmed delay.
// - Start delay adds to filter latency before the first ready indication.
// - Offset is subtracted from raw data before the gain multiply.
// - Output equals (raw minus offset) times gain over 400000h.
// - Round to 16 or 24 bits, then clip at full scale codes.
// - Offset is signed 24 bits, high byte at 09h, low byte at 0Bh.
// - In 16-bit mode the full offset still applies before rounding.
// - Gain is unsigned 24 bits, high byte at 0Ch, unity at 400000h.
// - Serial mode 1: clock idles low, drive on rise, sample on fall.
// - Frame runs from chip select falling to chip select rising.
// - At frame end decode last 16 bits, or last 24 with CRC.
// - Chip select high resets serial logic and floats output pin.
// - Full duplex: next command shifts in while data shifts out.
// - A setup bit muxes data ready onto the serial output pin.
// - Frame length is resolution plus optional status and CRC bytes.
// - After reset the output frame is 24 bits.
// - Commands: 00h 00h no-op, 40h+addr read, 80h+addr write.
// - With CRC on, bad command CRC blocks execution and sets error.
`ifndef ACSF_CONSTS_VH
`define ACSF_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ACSF_ADDR_STATUS   4'h2
`define ACSF_ADDR_CONTROL  4'h3
`define ACSF_ADDR_SETUP2   4'h6
`define ACSF_ADDR_SETUP3   4'h7
`define ACSF_ADDR_SETUP4   4'h8
`define ACSF_ADDR_OFS_H    4'h9
`define ACSF_ADDR_OFS_M    4'hA
`define ACSF_ADDR_OFS_L    4'hB
`define ACSF_ADDR_GAIN_H   4'hC
`define ACSF_ADDR_GAIN_M   4'hD
`define ACSF_ADDR_GAIN_L   4'hE

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ACSF_STATUS_ERR_BIT   0
`define ACSF_STATUS_NEW_BIT   1
`define ACSF_CTRL_START_BIT   0
`define ACSF_CTRL_STOP_BIT    1
`define ACSF_SETUP2_SDO_BIT   0
`define ACSF_SETUP3_DLY_MSB   7
`define ACSF_SETUP3_DLY_LSB   5
`define ACSF_SETUP4_CRC_BIT   0
`define ACSF_SETUP4_STAT_BIT  1
`define ACSF_SETUP4_RES16_BIT 2
`define ACSF_REG_RESET        8'h00
`define ACSF_OFS_RESET        24'h000000
`define ACSF_GAIN_UNITY       24'h400000
`define ACSF_CMD_READ         4'h4
`define ACSF_CMD_WRITE        4'h8
`define ACSF_CRC_INIT         8'hFF
`define ACSF_CRC_POLY         8'h07

// ----------------------------------------
// Frame sizes in bits
// ----------------------------------------
`define ACSF_RES_HI_BITS  6'd24
`define ACSF_RES_LO_BITS  6'd16
`define ACSF_BYTE_BITS    6'd8

// ----------------------------------------
// Timing
// ----------------------------------------
`define ACSF_CLK_PERIOD_NS 10
`define ACSF_DELAY_UNIT_NS 1000
`define ACSF_LATENCY_NS    2000
`define ACSF_PERIOD_NS     2500
`define ACSF_DELAY_UNIT_CYC \
  ((`ACSF_DELAY_UNIT_NS + `ACSF_CLK_PERIOD_NS - 1) / `ACSF_CLK_PERIOD_NS)
`define ACSF_LATENCY_CYC \
  ((`ACSF_LATENCY_NS + `ACSF_CLK_PERIOD_NS - 1) / `ACSF_CLK_PERIOD_NS)
`define ACSF_PERIOD_CYC (`ACSF_PERIOD_NS / `ACSF_CLK_PERIOD_NS)

`endif

// File: hw/acsf_crc8.v
`include "acsf_consts.vh"
module acsf_crc8 #(
  parameter WIDTH = 16
) (
  input  wire [WIDTH-1:0] data,
  output wire [7:0]       crc
);

  // ----------------------------------------
  // Bitwise remainder, MSB first
  // ----------------------------------------
  // Preset of all ones catches a stuck-low line
  reg     [7:0] crcV;
  integer       i;

  always @*
  begin
    crcV = `ACSF_CRC_INIT;
    for (i = WIDTH - 1; i >= 0; i = i - 1)
    begin
      crcV = {crcV[6:0], 1'b0} ^
             ((crcV[7] ^ data[i]) ? `ACSF_CRC_POLY : 8'h00);
    end
  end

  assign crc = crcV;

endmodule

// File: hw/acsf_calib.v
module acsf_calib (
  input  wire        clk,
  input  wire        rst,
  input  wire [23:0] rawData,
  input  wire        rawValid,
  input  wire [23:0] offsetVal,
  input  wire [23:0] gainVal,
  input  wire        res16,
  output reg  [23:0] calData_q,
  output reg         calValid_q
);

  // ----------------------------------------
  // Offset, gain, full-precision product
  // ----------------------------------------
  localparam signed [49:0] HALF24 = 50'sh200000;
  localparam signed [49:0] HALF16 = 50'sh20000000;
  localparam signed [49:0] MAX24  = 50'sh7FFFFF;
  localparam signed [49:0] MIN24  = -50'sh800000;
  localparam signed [49:0] MAX16  = 50'sh7FFF;
  localparam signed [49:0] MIN16  = -50'sh8000;

  wire signed [24:0] diff = $signed({rawData[23], rawData}) -
                            $signed({offsetVal[23], offsetVal});
  wire signed [24:0] gainS = $signed({1'b0, gainVal});
  wire signed [49:0] prod  = diff * gainS;
  // Divide by unity gain folded into the rounding shift
  wire signed [49:0] rnd24 = (prod + HALF24) >>> 22;
  wire signed [49:0] rnd16 = (prod + HALF16) >>> 30;

  reg [23:0] clip_d;

  // ----------------------------------------
  // Saturation
  // ----------------------------------------
  always @*
  begin
    if (res16)
    begin
      if (rnd16 > MAX16)
        clip_d = 24'h007FFF;
      else if (rnd16 < MIN16)
        clip_d = 24'hFF8000;
      else
        clip_d = rnd16[23:0];
    end
    else
    begin
      if (rnd24 > MAX24)
        clip_d = 24'h7FFFFF;
      else if (rnd24 < MIN24)
        clip_d = 24'h800000;
      else
        clip_d = rnd24[23:0];
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      calData_q  <= 24'h000000;
      calValid_q <= 1'b0;
    end
    else
    begin
      calValid_q <= rawValid;
      if (rawValid)
        calData_q <= clip_d;
    end
  end

endmodule

// File: hw/acsf_top.v
`include "acsf_consts.vh"
module acsf_top #(
  parameter DELAY_UNIT_CYC = `ACSF_DELAY_UNIT_CYC,
  parameter LATENCY_CYC    = `ACSF_LATENCY_CYC,
  parameter PERIOD_CYC     = `ACSF_PERIOD_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        csN,
  input  wire        sclk,
  input  wire        sdi,
  input  wire        startPin,
  input  wire [23:0] rawData,
  output wire        serialOutReadyPin,
  output wire        serialOutReadyOe,
  output wire        resultReadyN
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg csS1_q, csS2_q, csS3_q;
  reg sclkS1_q, sclkS2_q, sclkS3_q;
  reg sdiS1_q, sdiS2_q;
  reg stS1_q, stS2_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      csS1_q   <= 1'b1;
      csS2_q   <= 1'b1;
      csS3_q   <= 1'b1;
      sclkS1_q <= 1'b0;
      sclkS2_q <= 1'b0;
      sclkS3_q <= 1'b0;
      sdiS1_q  <= 1'b0;
      sdiS2_q  <= 1'b0;
      stS1_q   <= 1'b0;
      stS2_q   <= 1'b0;
    end
    else
    begin
      csS1_q   <= csN;
      csS2_q   <= csS1_q;
      csS3_q   <= csS2_q;
      sclkS1_q <= sclk;
      sclkS2_q <= sclkS1_q;
      sclkS3_q <= sclkS2_q;
      sdiS1_q  <= sdi;
      sdiS2_q  <= sdiS1_q;
      stS1_q   <= startPin;
      stS2_q   <= stS1_q;
    end
  end

  wire csLow    = ~csS2_q;
  wire csFall   = csS3_q & ~csS2_q;
  wire csRise   = ~csS3_q & csS2_q;
  wire sclkRise = csLow & sclkS2_q & ~sclkS3_q;
  wire sclkFall = csLow & ~sclkS2_q & sclkS3_q;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] setup2_q, setup3_q, setup4_q;
  reg [7:0] ofsH_q, ofsM_q, ofsL_q;
  reg [7:0] gainH_q, gainM_q, gainL_q;
  reg       spiErr_q, newData_q, runBit_q;

  wire       crcEn  = setup4_q[`ACSF_SETUP4_CRC_BIT];
  wire       statEn = setup4_q[`ACSF_SETUP4_STAT_BIT];
  wire       res16  = setup4_q[`ACSF_SETUP4_RES16_BIT];
  wire       outPinFunctionSel = setup2_q[`ACSF_SETUP2_SDO_BIT];
  wire [2:0] delayCode =
    setup3_q[`ACSF_SETUP3_DLY_MSB:`ACSF_SETUP3_DLY_LSB];
  wire [7:0] statusByte = {6'h00, newData_q, spiErr_q};

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_DLY  = 2'd1;
  localparam [1:0] ST_LAT  = 2'd2;
  localparam [1:0] ST_RUN  = 2'd3;

  reg  [1:0]  state_q;
  reg  [19:0] cnt_q;
  reg         startLvl_q;
  reg         convDone_q;
  wire        startLvl  = stS2_q | runBit_q;
  wire        startEdge = startLvl & ~startLvl_q;
  wire [19:0] dlyCyc = DELAY_UNIT_CYC[19:0] << delayCode;

  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q    <= ST_IDLE;
      cnt_q      <= 20'h00000;
      startLvl_q <= 1'b0;
      convDone_q <= 1'b0;
    end
    else
    begin
      startLvl_q <= startLvl;
      convDone_q <= 1'b0;
      if (startEdge)
      begin
        // Only the first conversion of a run sees the delay
        if (delayCode == 3'd0)
        begin
          state_q <= ST_LAT;
          cnt_q   <= LATENCY_CYC[19:0] - 20'h00001;
        end
        else
        begin
          state_q <= ST_DLY;
          cnt_q   <= dlyCyc - 20'h00001;
        end
      end
      else if (cnt_q != 20'h00000)
        cnt_q <= cnt_q - 20'h00001;
      else
      begin
        case (state_q)
          ST_DLY:
          begin
            state_q <= ST_LAT;
            cnt_q   <= LATENCY_CYC[19:0] - 20'h00001;
          end
          ST_LAT, ST_RUN:
          begin
            convDone_q <= 1'b1;
            // A stop lets the ongoing conversion finish
            state_q    <= startLvl ? ST_RUN : ST_IDLE;
            cnt_q      <= PERIOD_CYC[19:0] - 20'h00001;
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  wire [23:0] calData;
  wire        calValid;

  acsf_calib u_calib (
    .clk        (clk),
    .rst        (rst),
    .rawData    (rawData),
    .rawValid   (convDone_q),
    .offsetVal  ({ofsH_q, ofsM_q, ofsL_q}),
    .gainVal    ({gainH_q, gainM_q, gainL_q}),
    .res16      (res16),
    .calData_q  (calData),
    .calValid_q (calValid)
  );

  // ----------------------------------------
  // Output frame assembly
  // ----------------------------------------
  reg         respReg_q;
  reg  [7:0]  respData_q;
  reg  [31:0] payload;
  reg  [39:0] frameWord;
  wire [5:0]  resBits  = res16 ? `ACSF_RES_LO_BITS : `ACSF_RES_HI_BITS;
  wire [5:0]  frameLen = resBits + (statEn ? `ACSF_BYTE_BITS : 6'd0) +
                         (crcEn ? `ACSF_BYTE_BITS : 6'd0);
  wire [5:0]  payLen   = frameLen - (crcEn ? `ACSF_BYTE_BITS : 6'd0);
  wire [7:0]  crc16, crc24, crc32;

  acsf_crc8 #(.WIDTH(16)) u_crc16 (.data(payload[31:16]), .crc(crc16));
  acsf_crc8 #(.WIDTH(24)) u_crc24 (.data(payload[31:8]),  .crc(crc24));
  acsf_crc8 #(.WIDTH(32)) u_crc32 (.data(payload),        .crc(crc32));

  always @*
  begin
    if (respReg_q)
      payload = {respData_q, 24'h000000};
    else if (res16)
      payload = statEn ? {statusByte, calData[15:0], 8'h00}
                       : {calData[15:0], 16'h0000};
    else
      payload = statEn ? {statusByte, calData} : {calData, 8'h00};
    if (!crcEn)
      frameWord = {payload, 8'h00};
    else if (payLen == 6'd16)
      frameWord = {payload[31:16], crc16, 16'h0000};
    else if (payLen == 6'd24)
      frameWord = {payload[31:8], crc24, 8'h00};
    else
      frameWord = {payload, crc32};
  end

  // ----------------------------------------
  // Serial shifter and command decode
  // ----------------------------------------
  reg  [39:0] outShift_q;
  reg  [23:0] inShift_q;
  reg  [5:0]  bitCnt_q;
  reg         sdo_q, shifted_q, dataFrame_q, readyN_q;
  reg  [7:0]  rdData;
  wire [15:0] cmd   = crcEn ? inShift_q[23:8] : inShift_q[15:0];
  wire [7:0]  crcIn;
  wire        crcOk = ~crcEn | (crcIn == inShift_q[7:0]);
  wire [3:0]  addr  = cmd[11:8];
  wire [3:0]  op    = cmd[15:12];
  wire        doWr  = csRise & crcOk & (op == `ACSF_CMD_WRITE) &
                      (~spiErr_q | (addr == `ACSF_ADDR_STATUS));
  wire        doRd  = csRise & crcOk & (op == `ACSF_CMD_READ);

  acsf_crc8 #(.WIDTH(16)) u_crcCmd (.data(inShift_q[23:8]), .crc(crcIn));

  always @*
  begin
    case (addr)
      `ACSF_ADDR_STATUS: rdData = statusByte;
      `ACSF_ADDR_SETUP2: rdData = setup2_q;
      `ACSF_ADDR_SETUP3: rdData = setup3_q;
      `ACSF_ADDR_SETUP4: rdData = setup4_q;
      `ACSF_ADDR_OFS_H:  rdData = ofsH_q;
      `ACSF_ADDR_OFS_M:  rdData = ofsM_q;
      `ACSF_ADDR_OFS_L:  rdData = ofsL_q;
      `ACSF_ADDR_GAIN_H: rdData = gainH_q;
      `ACSF_ADDR_GAIN_M: rdData = gainM_q;
      `ACSF_ADDR_GAIN_L: rdData = gainL_q;
      default:           rdData = 8'h00;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      outShift_q  <= 40'h0000000000;
      inShift_q   <= 24'h000000;
      bitCnt_q    <= 6'd0;
      sdo_q       <= 1'b0;
      shifted_q   <= 1'b0;
      dataFrame_q <= 1'b0;
      respReg_q   <= 1'b0;
      respData_q  <= 8'h00;
    end
    else if (!csLow)
    begin
      bitCnt_q  <= 6'd0;
      shifted_q <= 1'b0;
      inShift_q <= 24'h000000;
      if (doRd)
      begin
        // Register answer goes out in the next frame
        respReg_q  <= 1'b1;
        respData_q <= rdData;
      end
    end
    else if (csFall)
    begin
      outShift_q  <= frameWord;
      dataFrame_q <= ~respReg_q;
      respReg_q   <= 1'b0;
    end
    else
    begin
      if (sclkRise)
      begin
        sdo_q      <= outShift_q[39];
        outShift_q <= {outShift_q[38:0], 1'b0};
        shifted_q  <= 1'b1;
      end
      if (sclkFall)
      begin
        inShift_q <= {inShift_q[22:0], sdiS2_q};
        if (bitCnt_q != 6'h3F)
          bitCnt_q <= bitCnt_q + 6'd1;
      end
    end
  end

  // ----------------------------------------
  // Register writes and flags
  // ----------------------------------------
  // Ready returns high on the fourth falling clock of a data read
  wire readDone = sclkFall & dataFrame_q & (bitCnt_q == 6'd3);

  always @(posedge clk)
  begin
    if (rst)
    begin
      setup2_q  <= `ACSF_REG_RESET;
      setup3_q  <= `ACSF_REG_RESET;
      setup4_q  <= `ACSF_REG_RESET;
      {ofsH_q, ofsM_q, ofsL_q}    <= `ACSF_OFS_RESET;
      {gainH_q, gainM_q, gainL_q} <= `ACSF_GAIN_UNITY;
      spiErr_q  <= 1'b0;
      newData_q <= 1'b0;
      runBit_q  <= 1'b0;
      readyN_q  <= 1'b1;
    end
    else
    begin
      if (doWr)
      begin
        case (addr)
          `ACSF_ADDR_SETUP2: setup2_q <= cmd[7:0];
          `ACSF_ADDR_SETUP3: setup3_q <= cmd[7:0];
          `ACSF_ADDR_SETUP4: setup4_q <= cmd[7:0];
          `ACSF_ADDR_OFS_H:  ofsH_q   <= cmd[7:0];
          `ACSF_ADDR_OFS_M:  ofsM_q   <= cmd[7:0];
          `ACSF_ADDR_OFS_L:  ofsL_q   <= cmd[7:0];
          `ACSF_ADDR_GAIN_H: gainH_q  <= cmd[7:0];
          `ACSF_ADDR_GAIN_M: gainM_q  <= cmd[7:0];
          `ACSF_ADDR_GAIN_L: gainL_q  <= cmd[7:0];
          `ACSF_ADDR_CONTROL:
          begin
            if (cmd[`ACSF_CTRL_STOP_BIT])
              runBit_q <= 1'b0;
            else if (cmd[`ACSF_CTRL_START_BIT])
              runBit_q <= 1'b1;
          end
          default:
            runBit_q <= runBit_q;
        endcase
      end
      // Set wins over the write-one clear
      if (csRise & ~crcOk)
        spiErr_q <= 1'b1;
      else if (doWr & (addr == `ACSF_ADDR_STATUS) &
               cmd[`ACSF_STATUS_ERR_BIT])
        spiErr_q <= 1'b0;
      if (calValid)
        newData_q <= 1'b1;
      else if (readDone)
        newData_q <= 1'b0;
      if (calValid)
        readyN_q <= 1'b0;
      else if (startEdge | readDone)
        readyN_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  // Before the first rising clock the pin mirrors data ready
  assign serialOutReadyPin = (outPinFunctionSel & ~shifted_q) ?
                             readyN_q : sdo_q;
  assign serialOutReadyOe  = csLow;
  assign resultReadyN      = readyN_q;

endmodule

// File: verification/acsf_host.sv
module acsf_host (
  output logic csN,
  output logic sclk,
  output logic sdi,
  input  wire  pin,
  input  wire  oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------
  // Line level and frame driver
  // ------------------------------------
  logic lastPin = 1'b0;
  // Released pin shows the inverse so a stale bit never passes
  wire  lineLvl = oe ? pin : ~lastPin;

  always @*
  begin
    if (oe)
      lastPin = pin;
  end

  initial
  begin
    csN = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
  end

  // Zero bits: select only, then sample the pin once
  task automatic frame(input logic [39:0] tx, input int n,
                       output logic [39:0] rx);
    rx = '0;
    csN = 1'b0;
    #400;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk = 1'b1;
      sdi = tx[i];
      #62.5;
      sclk = 1'b0;
      rx = {rx[38:0], lineLvl};
      #62.5;
    end
    if (n == 0)
      rx[0] = lineLvl;
    csN = 1'b1;
    sdi = 1'b1;
    #400;
  endtask
endmodule

// File: verification/acsf_monitor.sv
module acsf_monitor #(
  parameter int DELAY_UNIT_CYC = 100,
  parameter int LATENCY_CYC    = 200,
  parameter int PERIOD_CYC     = 250
) (
  input wire        clk,
  input wire        rst,
  input wire        csN,
  input wire        sclk,
  input wire        sdi,
  input wire        startPin,
  input wire [23:0] rawData,
  input wire        serialOutReadyPin,
  input wire        serialOutReadyOe,
  input wire        resultReadyN
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------
  // Helper counters
  // ------------------------------------
  logic       sclkD_q;
  logic       startD_q;
  logic       begun_q;
  logic [3:0] sinceRise_q;
  logic [9:0] sinceStart_q;

  always @(posedge clk)
  begin
    sclkD_q <= sclk;
    startD_q <= startPin;
    if (rst)
    begin
      begun_q <= 1'b0;
      sinceRise_q <= 4'hF;
      sinceStart_q <= 10'h000;
    end
    else
    begin
      if (sclk && !sclkD_q)
        sinceRise_q <= 4'h1;
      else if (sinceRise_q != 4'hF)
        sinceRise_q <= sinceRise_q + 4'h1;
      if (csN)
        begun_q <= 1'b0;
      else if (sclk && !sclkD_q)
        begun_q <= 1'b1;
      if (startPin && !startD_q)
        sinceStart_q <= 10'h000;
      else if (sinceStart_q != 10'h3FF)
        sinceStart_q <= sinceStart_q + 10'h001;
    end
  end

  // ------------------------------------
  // Properties
  // ------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_RST_IDLE:
    assert property (disable iff (1'b0) rst |=> !serialOutReadyOe
      && !serialOutReadyPin && resultReadyN)
    else $error("outputs active after reset");
  AST_CS_FLOAT:
    assert property (csN [*6] |-> !serialOutReadyOe)
    else $error("pin driven while deselected");
  AST_CS_DRIVE:
    assert property (!csN [*6] |-> serialOutReadyOe)
    else $error("pin not driven in frame");
  AST_OE_RISE:
    assert property ($rose(serialOutReadyOe) |-> !csN && !$past(csN))
    else $error("drive began without select");
  AST_OE_FALL:
    assert property ($fell(serialOutReadyOe) |-> csN && $past(csN))
    else $error("drive ended inside frame");
  // Mux mode may move the pin before the first clock, hence begun_q
  AST_PIN_ON_RISE:
    assert property (serialOutReadyOe && $past(serialOutReadyOe) && begun_q
      && !csN && !$past(csN, 4) && $changed(serialOutReadyPin)
      |-> sinceRise_q inside {[4'h1:4'h8]})
    else $error("pin moved away from clock rise");
  AST_READY_LATENCY:
    assert property ($fell(resultReadyN) |-> sinceStart_q >= LATENCY_CYC)
    else $error("ready earlier than latency");
  AST_READY_ON_START:
    assert property ($rose(startPin) |-> ##[1:6] resultReadyN)
    else $error("ready not raised at start");

  cover property ($rose(serialOutReadyOe));
  cover property ($fell(resultReadyN));
  cover property (begun_q && $changed(serialOutReadyPin));
endmodule

bind acsf_top acsf_monitor #(
  .DELAY_UNIT_CYC(DELAY_UNIT_CYC),
  .LATENCY_CYC(LATENCY_CYC),
  .PERIOD_CYC(PERIOD_CYC)
) mon (.clk(clk), .rst(rst), .csN(csN), .sclk(sclk), .sdi(sdi),
  .startPin(startPin), .rawData(rawData),
  .serialOutReadyPin(serialOutReadyPin),
  .serialOutReadyOe(serialOutReadyOe), .resultReadyN(resultReadyN));

// File: verification/acsf_tb.sv
`include "acsf_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------
  // Signals and tables
  // ------------------------------------
  localparam int DU = 2;
  localparam int LAT = 5;
  // Long period lets a full frame fit between two results
  localparam int PER = 400;
  logic        clk;
  logic        rst;
  logic        startPin;
  logic [23:0] rawData;
  wire         csN;
  wire         sclk;
  wire         sdi;
  wire         pin;
  wire         oe;
  wire         resultReadyN;
  logic [39:0] rx;
  int          flen;
  bit          crcOn;
  int          errors;
  int          comparisons;
  int          t[8];
  int          tA;
  logic [23:0] rawTab[5] = '{24'h100000, 24'h200000, 24'h7FFFF0,
                             24'h800010, 24'h123480};
  logic [23:0] ofsTab[5] = '{24'h000010, 24'h000000, 24'hFFFFF0,
                             24'h000020, 24'h000081};
  logic [23:0] gainTab[5] = '{24'h400000, 24'h433333, 24'h600000,
                              24'hC00000, 24'h400000};
  logic [7:0]  cfgTab[5] = '{8'h00, 8'h02, 8'h00, 8'h06, 8'h04};

  acsf_top #(.DELAY_UNIT_CYC(DU), .LATENCY_CYC(LAT), .PERIOD_CYC(PER)) dut (
    .clk(clk), .rst(rst), .csN(csN), .sclk(sclk), .sdi(sdi),
    .startPin(startPin), .rawData(rawData), .serialOutReadyPin(pin),
    .serialOutReadyOe(oe), .resultReadyN(resultReadyN));
  acsf_host host (.csN(csN), .sclk(sclk), .sdi(sdi), .pin(pin), .oe(oe));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------
  // Helpers
  // ------------------------------------
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c = 8'hFF;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  function automatic logic [23:0] cal(input logic [23:0] r, o, g,
                                      input bit s16);
    longint p;
    longint lim;
    p = (longint'($signed(r)) - longint'($signed(o))) * longint'(g);
    lim = s16 ? 64'sd32767 : 64'sd8388607;
    p = s16 ? (p + (64'sd1 <<< 29)) >>> 30 : (p + (64'sd1 <<< 21)) >>> 22;
    if (p > lim)
      p = lim;
    if (p < -lim - 1)
      p = -lim - 1;
    return p[23:0];
  endfunction

  task automatic chkV(input logic [23:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkT(input int got, exp);
    comparisons++;
    if (got != exp)
    begin
      errors++;
      $display("BAD %0t cycles %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] b1, b2, input logic bad = 1'b0);
    logic [39:0] tx;
    tx = {24'h0, b1, b2};
    if (crcOn)
      tx = {16'h0, b1, b2, crc8({b1, b2}) ^ {8{bad}}};
    host.frame(tx, flen, rx);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer({`ACSF_CMD_WRITE, a}, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    xfer({`ACSF_CMD_READ, a}, 8'h00);
    xfer(8'h00, 8'h00);
    chkV(rx[flen - 1 -: 8], e);
  endtask

  task automatic waitLow(input bit needHigh, output int n);
    bit hi;
    hi = !needHigh;
    n = 0;
    while (!(hi && resultReadyN === 1'b0) && n < 3000)
    begin
      @(posedge clk) #1;
      n++;
      hi = hi | (resultReadyN === 1'b1);
    end
    if (n >= 3000)
      errors++;
  endtask

  task automatic startRun(input logic [2:0] code, output int n);
    wr(`ACSF_ADDR_SETUP3, {code, 5'h00});
    @(posedge clk) #1 startPin = 1'b0;
    repeat (2 * PER) @(posedge clk);
    #1 startPin = 1'b1;
    waitLow(1'b1, n);
  endtask

  task automatic close_out;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #600000;
    errors++;
    close_out();
  end

  // ------------------------------------
  // Sequence
  // ------------------------------------
  initial
  begin
    rst = 1'b1;
    startPin = 1'b0;
    rawData = 24'h000000;
    flen = 24;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    chkV(oe, 1'b0);
    chkV(resultReadyN, 1'b1);
    xfer(8'h4C, 8'h00);
    xfer(8'h49, 8'h00);
    chkV(rx[23:16], 8'h40);
    xfer(8'h4F, 8'h00);
    chkV(rx[23:16], 8'h00);
    xfer(8'h00, 8'h00);
    chkV(rx[23:16], 8'h00);
    host.frame({8'h00, 8'hFF, 8'hFF, 8'h8A, 8'h3C}, 40, rx);
    rd(`ACSF_ADDR_OFS_M, 8'h3C);
    startRun(3'h0, t[0]);
    startRun(3'h1, t[1]);
    chkT(t[1] - t[0], DU << 1);
    startRun(3'h7, t[7]);
    chkT(t[7] - t[0], DU << 7);
    tA = int'($time);
    xfer(8'h00, 8'h00);
    waitLow(1'b1, t[2]);
    chkT((int'($time) - tA) / 10, PER);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk) #1 rawData = rawTab[i];
      for (int k = 0; k < 3; k++)
      begin
        wr(4'(9 + k), ofsTab[i][23 - 8 * k -: 8]);
        wr(4'(12 + k), gainTab[i][23 - 8 * k -: 8]);
      end
      wr(`ACSF_ADDR_SETUP4, cfgTab[i]);
      flen = (cfgTab[i][2] ? 16 : 24) + (cfgTab[i][1] ? 8 : 0);
      repeat (3 * PER) @(posedge clk);
      xfer(8'h00, 8'h00);
      if (cfgTab[i][2])
        chkV(rx[15:0], cal(rawTab[i], ofsTab[i], gainTab[i], 1'b1) & 24'hFFFF);
      else
        chkV(rx[23:0], cal(rawTab[i], ofsTab[i], gainTab[i], 1'b0));
    end
    wr(`ACSF_ADDR_SETUP4, 8'h01);
    crcOn = 1'b1;
    flen = 32;
    xfer(8'h89, 8'h55, 1'b1);
    xfer(8'h89, 8'h77);
    rd(`ACSF_ADDR_OFS_H, ofsTab[4][23:16]);
    xfer(8'h42, 8'h00);
    xfer(8'h00, 8'h00);
    chkV(rx[24], 1'b1);
    xfer(8'h82, 8'h01);
    xfer(8'h88, 8'h00);
    crcOn = 1'b0;
    flen = 24;
    rd(`ACSF_ADDR_SETUP4, 8'h00);
    wr(`ACSF_ADDR_SETUP2, 8'h01);
    @(posedge clk) #1 startPin = 1'b0;
    repeat (2 * PER) @(posedge clk);
    wr(`ACSF_ADDR_CONTROL, 8'h01);
    waitLow(1'b1, t[3]);
    chkT(int'(t[3] >= (DU << 7) - 40 && t[3] <= (DU << 7)), 1);
    wr(`ACSF_ADDR_CONTROL, 8'h02);
    repeat (2 * PER) @(posedge clk);
    host.frame(40'h0, 0, rx);
    chkV(rx[0], 1'b0);
    chkV(resultReadyN, 1'b0);
    close_out();
  end
endmodule
